// *** txpe_encoder.sv ***
// Transmit parity check, 8B/10B encoder and serial shifter.
// Assumes host inputs synchronous to clock_in and held while tx_load_out.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

// Contract
// RQ1: Odd parity checking with the extra parity bit works in every mode.
// RQ2: Parity middle with encoder on checks data bits and parity bit only.
// RQ3: Parity high encoded, or middle bypassed, also checks both control bits.
// RQ4: Parity control low disables all parity checking.
// RQ5: Parity is good only when the XOR of checked bits is one.
// RQ6: Encoded parity error sends the violation symbol with correct disparity; the code sends K28.5 in atomic word sync and sequence data in self test.
// RQ7: Bypass parity error sends the fixed positive violation pattern; the code sends the negative form rev10(VIOL_STR) whatever rd is.
// RQ8: Every detected parity error shows on the transmit error flag; the code holds the flag low during atomic word sync and self test.
// RQ9: Each character and control bits become one ten-bit character.
// RQ10: Phase-align buffer error forces the violation symbol; the code sends the self-test sequence instead while self test is on.
// RQ11: Self test takes characters from a 511-long sequence.
// RQ12: K28.5 goes out as single fill or in a 16-long word sync.
// RQ13: Encoded mode uses special rules for specials, data rules otherwise.
// RQ14: Two separate non-overlapping special-code tables are accepted.
// RQ15: Characters are shifted out least significant bit first.
// RQ16: Two three-level mode inputs choose among nine transmit modes.
// RQ17: Modes three to eight each map select and control bits differently.
// RQ18: Bypass passes the ten captured bits unchanged as plain data.
// RQ19: Bypass maps data 0..7 to a,b,c,d,e,i,f,g, control to h,j.
// RQ20: Bypass ignores special select; all clockings read data alike.
// RQ21: Host avoids the two factory test modes in normal use.
// RQ22: Parity bit is captured with each character, used per parity control.
// RQ23: Input register takes eight data and two control bits per character.
// RQ24: Running disparity is kept across characters and picks each form.
module txpe_encoder (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Host character interface
    input wire logic [7:0] tx_data_in,
    input wire logic [1:0] tx_control_in,
    input wire logic special_char_select_in,
    input wire logic tx_odd_parity_bit_in,
    output logic tx_load_out,
    // Three-level configuration pins
    input wire logic [1:0] parity_check_control_in,
    input wire logic [3:0] tx_mode_select_in,
    // Phase-align buffer status
    input wire logic phase_align_err_in,
    // Towards the line
    output logic [9:0] tx_char_out,
    output logic tx_char_valid_out,
    output logic serial_out,
    output logic tx_error_flag_out,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out
);

    // ------------------------------------------------------------
    // Code helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] rev10(input logic [9:0] s);
        logic [9:0] r;
        r = '0;
        for (int i = 0; i < 10; i++) begin
            r[i] = s[9 - i];
        end
        return r;
    endfunction

    // Returns {running disparity after, code with bit 0 sent first}
    function automatic logic [10:0] enc_core(input logic [4:0] x,
        input logic [5:0] s, input logic [2:0] y, input logic is_k,
        input logic rd);
        logic [5:0] s6;
        logic [3:0] f4;
        logic r6;
        logic ro;
        logic a7;
        s6 = s;
        r6 = rd;
        if ($countones(s) != 3) begin
            if (rd) s6 = ~s;
            r6 = ~rd;
        end else if (!is_k && x == 5'h07 && rd) begin
            s6 = ~s;
        end
        // Alternate x.7 avoids a run of five in the e,i,f,g,h region
        a7 = (y == 3'h7) && (is_k ||
            (!r6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
            (r6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        f4 = a7 ? txpe_pkg::A7_4B : txpe_pkg::TAB4[y];
        ro = r6;
        if ($countones(f4) != 2) begin
            if (r6) f4 = ~f4;
            ro = ~r6;
        end else if (y == 3'h3 && r6) begin
            f4 = ~f4;
        end
        return {ro, rev10({s6, f4})};
    endfunction

    function automatic logic [10:0] enc_d(input logic [7:0] v,
        input logic rd);
        return enc_core(v[4:0], txpe_pkg::TAB6[v[4:0]], v[7:5], 1'b0, rd);
    endfunction

    // Specials are built in negative form and inverted whole when positive
    function automatic logic [10:0] enc_k(input logic [7:0] v,
        input logic rd);
        logic [10:0] c;
        c = enc_core(v[4:0], (v[4:0] == txpe_pkg::K28_X) ?
            txpe_pkg::K28_6B : txpe_pkg::TAB6[v[4:0]], v[7:5], 1'b1, 1'b0);
        return {c[10] ^ rd, rd ? ~c[9:0] : c[9:0]};
    endfunction

    // {valid, special code}; the two input tables never share a code
    function automatic logic [8:0] spec_map(input logic [7:0] v);
        logic [4:0] x;
        x = v[4:0];
        if (x == txpe_pkg::K28_X) begin
            return {1'b1, v};
        end else if (v[7:5] == 3'h7 && (x == 5'h17 || x == 5'h1B ||
                x == 5'h1D || x == 5'h1E)) begin
            return {1'b1, v};
        end else if (v[7:3] == 5'h00) begin
            return {1'b1, v[2:0], txpe_pkg::K28_X};
        end else if (v[7:2] == 6'h02) begin
            return {1'b1, txpe_pkg::SPEC_TAB2[v[1:0]]};
        end else begin
            return {1'b0, v};
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [3:0] char_cnt;
    logic enc_go;
    logic [7:0] cap_data;
    logic [1:0] cap_ctl;
    logic cap_special_char_select;
    logic cap_op;
    logic [1:0] cap_pc;
    logic [3:0] cap_mode;
    logic rd;
    logic [8:0] lfsr;
    logic [3:0] ws_cnt;
    logic [9:0] shreg;
    logic [1:0] ctrl;
    logic [15:0] err_cnt;
    txpe_pkg::txpe_ws_e ws_state;
    txpe_pkg::txpe_ws_e next_ws;
    txpe_pkg::txpe_char_e kind;
    logic enc_on;
    logic atomic_on;
    logic chk_all;
    logic perr;
    logic [8:0] spec;
    logic [10:0] k285;
    logic [9:0] viol;
    logic [10:0] fresh_code;
    logic fresh_err;
    logic fresh_ws;
    logic [10:0] next_code;
    logic next_err;
    logic [3:0] next_cnt;
    logic [8:0] next_lfsr;
    logic wb_req;

    // ------------------------------------------------------------
    // Character timing and input register
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            char_cnt <= 4'h0;
            tx_load_out <= 1'b0;
            enc_go <= 1'b0;
        end else begin
            char_cnt <= (char_cnt == txpe_pkg::CNT_LAST) ? 4'h0 :
                char_cnt + 4'h1;
            tx_load_out <= (char_cnt == txpe_pkg::CNT_LOAD);
            enc_go <= tx_load_out;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cap_data <= 8'h00;
            cap_ctl <= 2'h0;
            cap_special_char_select <= 1'b0;
            cap_op <= 1'b1;
            cap_pc <= txpe_pkg::LVL_L;
            cap_mode <= 4'h0;
        end else if (tx_load_out) begin
            cap_data <= tx_data_in; // RQ23
            cap_ctl <= tx_control_in; // RQ23
            cap_special_char_select <= special_char_select_in;
            cap_op <= tx_odd_parity_bit_in; // RQ22
            cap_pc <= parity_check_control_in;
            cap_mode <= tx_mode_select_in;
        end
    end

    // ------------------------------------------------------------
    // Parity check and character selection
    // ------------------------------------------------------------
    // Test modes LM and LH behave as bypass
    assign enc_on = (cap_mode[3:2] != txpe_pkg::LVL_L); // RQ16 RQ21
    assign atomic_on = (cap_mode[3:2] == txpe_pkg::LVL_M); // RQ16
    assign chk_all = cap_pc[1] || !enc_on; // RQ3
    assign perr = (cap_pc != txpe_pkg::LVL_L) && // RQ1 RQ4
        ((^cap_data ^ cap_op ^ (chk_all ? ^cap_ctl : 1'b0)) != 1'b1); // RQ2 RQ5

    always_comb begin
        spec = spec_map(cap_data); // RQ14
        k285 = enc_k(txpe_pkg::K28_5, rd);
        viol = rd ? ~rev10(txpe_pkg::VIOL_STR) : rev10(txpe_pkg::VIOL_STR);
        kind = txpe_pkg::TXPE_CH_DATA;
        case (cap_mode[1:0]) // RQ17
            txpe_pkg::LVL_L: begin
                if (cap_ctl == 2'h3) kind = txpe_pkg::TXPE_CH_WSYNC;
                else if (cap_ctl[0]) kind = cap_special_char_select ?
                    txpe_pkg::TXPE_CH_SPEC : txpe_pkg::TXPE_CH_FILL;
            end
            txpe_pkg::LVL_M: begin
                if (cap_ctl[0] && cap_special_char_select) kind = txpe_pkg::TXPE_CH_WSYNC;
                else if (cap_ctl[0]) kind = cap_ctl[1] ?
                    txpe_pkg::TXPE_CH_SPEC : txpe_pkg::TXPE_CH_FILL;
            end
            default: begin
                kind = txpe_pkg::txpe_char_e'(cap_ctl);
            end
        endcase
        fresh_err = 1'b0;
        fresh_ws = 1'b0;
        // Bypass: bit order a,b,c,d,e,i,f,g,h,j equals the input order
        fresh_code = {rd, cap_ctl, cap_data}; // RQ18 RQ19 RQ20
        if (perr) begin
            fresh_err = 1'b1; // RQ8
            fresh_code = enc_on ? {rd, viol} : // RQ6
                {rd, rev10(txpe_pkg::VIOL_STR)}; // RQ7
        end else if (!enc_on) begin
            fresh_code = {rd, cap_ctl, cap_data}; // RQ18
        end else if (ctrl[txpe_pkg::CTRL_FILL_BIT]) begin
            fresh_code = k285;
        end else begin
            case (kind) // RQ9 RQ13
                txpe_pkg::TXPE_CH_DATA: fresh_code = enc_d(cap_data, rd);
                txpe_pkg::TXPE_CH_FILL: fresh_code = k285; // RQ12
                txpe_pkg::TXPE_CH_SPEC: fresh_code = spec[8] ?
                    enc_k(spec[7:0], rd) : {rd, viol};
                default: begin
                    fresh_code = k285; // RQ12
                    fresh_ws = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Word sync, self test and error overrides
    // ------------------------------------------------------------
    always_comb begin
        next_ws = ws_state;
        next_cnt = ws_cnt;
        next_lfsr = lfsr;
        next_code = fresh_code;
        next_err = fresh_err;
        if (ctrl[txpe_pkg::CTRL_BIST_BIT]) begin
            next_code = enc_d(lfsr[7:0], rd); // RQ11
            next_err = 1'b0;
            next_lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]}; // RQ11
            next_ws = txpe_pkg::TXPE_WS_IDLE;
        end else if (phase_align_err_in) begin
            next_code = {rd, viol}; // RQ10
            next_err = 1'b1;
            next_ws = txpe_pkg::TXPE_WS_IDLE;
        end else begin
            case (ws_state)
                txpe_pkg::TXPE_WS_ATOMIC: begin
                    // Input register and parity ignored until the end
                    next_code = k285; // RQ12
                    next_err = 1'b0;
                    next_cnt = ws_cnt - 4'h1;
                    if (ws_cnt == 4'h1) next_ws = txpe_pkg::TXPE_WS_IDLE;
                end
                txpe_pkg::TXPE_WS_INTR: begin
                    if (cap_ctl == 2'h0 && !perr) begin
                        next_code = k285; // RQ12
                        next_cnt = ws_cnt - 4'h1;
                        if (ws_cnt == 4'h1) next_ws = txpe_pkg::TXPE_WS_IDLE;
                    end else if (fresh_ws) begin
                        next_ws = txpe_pkg::TXPE_WS_INTR;
                        next_cnt = txpe_pkg::WS_REMAIN;
                    end else begin
                        next_ws = txpe_pkg::TXPE_WS_IDLE;
                    end
                end
                default: begin
                    if (fresh_ws) begin
                        next_ws = atomic_on ? txpe_pkg::TXPE_WS_ATOMIC :
                            txpe_pkg::TXPE_WS_INTR;
                        next_cnt = txpe_pkg::WS_REMAIN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ws_state <= txpe_pkg::TXPE_WS_IDLE;
            ws_cnt <= 4'h0;
            lfsr <= txpe_pkg::LFSR_SEED;
        end else if (enc_go) begin
            ws_state <= next_ws;
            ws_cnt <= next_cnt;
            lfsr <= next_lfsr;
        end
    end

    // ------------------------------------------------------------
    // Output character, disparity and shifter
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            tx_char_out <= 10'h000;
            tx_char_valid_out <= 1'b0;
            tx_error_flag_out <= 1'b0;
            rd <= 1'b0;
        end else begin
            tx_char_valid_out <= enc_go;
            if (enc_go) begin
                tx_char_out <= next_code[9:0]; // RQ9
                tx_error_flag_out <= next_err; // RQ8
                rd <= next_code[10]; // RQ24
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            shreg <= 10'h000;
            serial_out <= 1'b0;
        end else if (enc_go) begin
            serial_out <= next_code[0]; // RQ15
            shreg <= {1'b0, next_code[9:1]};
        end else begin
            serial_out <= shreg[0]; // RQ15
            shreg <= {1'b0, shreg[9:1]};
        end
    end

    // ------------------------------------------------------------
    // Wishbone registers
    // ------------------------------------------------------------
    assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_req;
            if (wb_req && !wb_we_in) begin
                if (wb_adr_in == txpe_pkg::ADR_CTRL) begin
                    wb_dat_out <= {30'h0000_0000, ctrl};
                end else if (wb_adr_in == txpe_pkg::ADR_STATUS) begin
                    wb_dat_out <= {28'h000_0000, ws_state != txpe_pkg::
                        TXPE_WS_IDLE, phase_align_err_in, rd,
                        tx_error_flag_out};
                end else if (wb_adr_in == txpe_pkg::ADR_ERRCNT) begin
                    wb_dat_out <= {16'h0000, err_cnt};
                end else begin
                    wb_dat_out <= 32'h0000_0000;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl <= txpe_pkg::CTRL_RST;
        end else if (wb_req && wb_we_in && wb_sel_in[0] &&
                wb_adr_in == txpe_pkg::ADR_CTRL) begin
            ctrl <= wb_dat_in[1:0];
        end
    end

    // A parity error in the clearing cycle counts as the first new one
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            err_cnt <= 16'h0000;
        end else if (enc_go && fresh_err && next_err) begin
            if (wb_req && wb_we_in && wb_adr_in == txpe_pkg::ADR_ERRCNT)
                err_cnt <= 16'h0001;
            else if (err_cnt != 16'hFFFF)
                err_cnt <= err_cnt + 16'h0001;
        end else if (wb_req && wb_we_in &&
                wb_adr_in == txpe_pkg::ADR_ERRCNT) begin
            err_cnt <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    logic plain_go;
    assign plain_go = enc_go && !ctrl[txpe_pkg::CTRL_BIST_BIT] &&
        !phase_align_err_in && ws_state == txpe_pkg::TXPE_WS_IDLE;

    AST_NO_CHECK_LOW: assert property ( // RQ4
        plain_go && cap_pc == txpe_pkg::LVL_L |=> !tx_error_flag_out)
        else $error("parity error flagged with checking off");
    AST_DATA_ONLY: assert property ( // RQ2
        plain_go && cap_pc == txpe_pkg::LVL_M && enc_on &&
        (^{cap_data, cap_op}) |=> !tx_error_flag_out)
        else $error("control bits wrongly included in parity");
    AST_ALL_BITS: assert property ( // RQ3
        plain_go && cap_pc == txpe_pkg::LVL_H && enc_on &&
        !(^{cap_data, cap_ctl, cap_op}) |=> tx_error_flag_out)
        else $error("full parity error not flagged");
    AST_BYPASS_PASS: assert property ( // RQ18
        plain_go && !enc_on && !perr |=>
        tx_char_out == {$past(cap_ctl), $past(cap_data)})
        else $error("bypass character altered");
    AST_BYPASS_VIOL: assert property ( // RQ7
        plain_go && !enc_on && perr |=>
        tx_char_out == rev10(txpe_pkg::VIOL_STR) && tx_error_flag_out)
        else $error("bypass parity error without violation pattern");
    AST_PAB_VIOL: assert property ( // RQ10
        enc_go && !ctrl[txpe_pkg::CTRL_BIST_BIT] && phase_align_err_in |=>
        (tx_char_out == rev10(txpe_pkg::VIOL_STR) ||
        tx_char_out == ~rev10(txpe_pkg::VIOL_STR)) && tx_error_flag_out)
        else $error("buffer error without violation symbol");
    AST_LSB_FIRST: assert property ( // RQ15
        tx_char_valid_out |-> serial_out == tx_char_out[0] ##1
        serial_out == $past(tx_char_out[1]) ##8
        serial_out == $past(tx_char_out[9], 9))
        else $error("serial order not lsb first");
    AST_DISPARITY: assert property ( // RQ24
        tx_char_valid_out && $past(enc_on) |->
        $countones(tx_char_out) >= 4 && $countones(tx_char_out) <= 6)
        else $error("encoded character unbalanced beyond one step");
    AST_ATOMIC_LEN: assert property ( // RQ12
        enc_go && ws_state == txpe_pkg::TXPE_WS_ATOMIC &&
        !ctrl[txpe_pkg::CTRL_BIST_BIT] && !phase_align_err_in |=>
        tx_char_out == $past(k285[9:0]))
        else $error("atomic word sync interrupted");
    AST_ACK_PULSE: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("wishbone ack held longer than one cycle");

    COV_BYPASS_PERR: cover property (plain_go && !enc_on && perr);
    COV_WS_START: cover property (plain_go && fresh_ws && atomic_on);
    COV_WS_INTR: cover property (
        enc_go && ws_state == txpe_pkg::TXPE_WS_INTR && cap_ctl != 2'h0);
    COV_BIST: cover property (enc_go && ctrl[txpe_pkg::CTRL_BIST_BIT]);

endmodule

// *** txpe_encoder_tb_top.sv ***
// Self-checking bench for the parity check and line encoder.
// Assumes the host model drives character and configuration pins; the bench drives the rest.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
    bad_count++; $display("Error at %0t: %s", $time, m); end end
module txpe_encoder_tb_top;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic phase_align_err_in = 1'b0;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h00000000;
    logic [7:0] tx_data_in;
    logic [1:0] tx_control_in, parity_check_control_in, pc;
    logic special_char_select_in, tx_odd_parity_bit_in, wb_ack_out;
    logic [3:0] tx_mode_select_in;
    logic [9:0] tx_char_out, sh, got, prev;
    logic tx_load_out, tx_char_valid_out, serial_out, tx_error_flag_out;
    logic [31:0] wb_dat_out, r, rd;
    logic gerr, e;
    int bad_count = 0;
    int n_compared = 0;
    int seed = 90938;
    int k = 10;
    int n_err = 0;

    always #2 clock_in = ~clock_in;

    txpe_host_model host (.tx_data_out(tx_data_in),
        .tx_control_out(tx_control_in),
        .special_char_select_out(special_char_select_in),
        .tx_odd_parity_bit_out(tx_odd_parity_bit_in),
        .parity_check_control_out(parity_check_control_in),
        .tx_mode_select_out(tx_mode_select_in));
    txpe_encoder dut (.*);

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic lost(input string m);
        bad_count++;
        $display("Error at %0t: %s", $time, m);
        wrap_up();
    endtask
    function automatic logic perr(input logic [7:0] d, input logic [1:0] c,
            input logic p, input logic [1:0] pc, input logic byp);
        if (pc == txpe_pkg::LVL_L) return 1'b0;
        if (pc == txpe_pkg::LVL_M && !byp) return ~^{d, p};
        return ~^{d, c, p};
    endfunction
    function automatic logic viol(input logic [9:0] x);
        return (x === 10'h079) || (x === 10'h386);
    endfunction

    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] w, output logic [31:0] q);
        int i;
        @(posedge clock_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_dat_in <= w;
        wb_sel_in <= 4'hF;
        for (i = 0; i < 20; i++) begin
            @(posedge clock_in);
            if (wb_ack_out === 1'b1) break;
        end
        if (i >= 20) lost("no bus ack");
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge clock_in);
    endtask

    // Drive after a non-capture edge so each character is taken once
    task automatic send(input logic [7:0] d, input logic [1:0] c,
            input logic s, input logic p, input logic [1:0] pc,
            input logic [3:0] md, input logic pa);
        int i;
        @(posedge clock_in);
        for (i = 0; i < 20 && tx_load_out !== 1'b0; i++) @(posedge clock_in);
        host.put(d, c, s, p, pc, md);
        phase_align_err_in <= pa;
        for (i = 0; i < 20; i++) begin
            @(posedge clock_in);
            if (tx_load_out === 1'b1) break;
        end
        for (i = 0; i < 20; i++) begin
            @(negedge clock_in);
            if (tx_char_valid_out === 1'b1) break;
        end
        if (i >= 20) lost("no character");
        got = tx_char_out;
        gerr = tx_error_flag_out;
    endtask

    always @(negedge clock_in) begin
        if (tx_char_valid_out === 1'b1) begin
            sh = tx_char_out;
            k = 0;
        end
        if (k < 10) begin
            `CHK(serial_out, sh[k], "serial bit")
            k++;
        end
    end

    initial begin
        #100000;
        lost("timeout");
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        send(8'hA5, 2'h2, 1'b1, 1'b0, txpe_pkg::LVL_L, 4'h0, 1'b0);
        `CHK(got, 10'h2A5, "bypass, check off")
        `CHK(gerr, 1'b0, "flag, check off")
        wb(1'b1, txpe_pkg::ADR_ERRCNT, 32'h00000000, rd);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            pc = (r[13:12] == 2'h3) ? 2'h1 : r[13:12];
            e = perr(r[7:0], r[9:8], r[11], pc, 1'b1);
            n_err += int'(e);
            send(r[7:0], r[9:8], r[10], r[11], pc, 4'h0, 1'b0);
            `CHK(got, e ? 10'h079 : r[9:0], "bypass char")
            `CHK(gerr, e, "bypass flag")
        end
        $display("bypass random done");
        send(8'h00, 2'h0, 1'b0, 1'b1, txpe_pkg::LVL_M, 4'h0, 1'b0);
        wb(1'b0, txpe_pkg::ADR_ERRCNT, 32'h00000000, rd);
        `CHK(rd[15:0], n_err[15:0], "error count")
        send(8'h00, 2'h1, 1'b0, 1'b1, txpe_pkg::LVL_M, 4'h6, 1'b0);
        prev = got;
        `CHK(got === 10'h17C || got === 10'h283, 1'b1, "fill")
        wb(1'b1, txpe_pkg::ADR_CTRL, 32'h2, rd);
        send(8'h00, 2'h2, 1'b0, 1'b1, txpe_pkg::LVL_M, 4'h6, 1'b0);
        `CHK(got, ~prev, "fill disparity")
        `CHK(gerr, 1'b0, "control bits excluded")
        wb(1'b1, txpe_pkg::ADR_CTRL, 32'h0, rd);
        send(8'h00, 2'h1, 1'b0, 1'b1, txpe_pkg::LVL_H, 4'h6, 1'b0);
        `CHK(viol(got), 1'b1, "encoded violation")
        `CHK(gerr, 1'b1, "encoded flag")
        $display("fill and parity done");
        for (int m = 0; m < 6; m++) begin
            r = $random(seed);
            pc = (r[13:12] == 2'h3) ? 2'h2 : r[13:12];
            e = perr(r[7:0], 2'h0, r[11], pc, 1'b0);
            send(r[7:0], 2'h0, r[10], r[11], pc,
                {((m < 3) ? 2'h1 : 2'h2), 2'(m % 3)}, 1'b0);
            `CHK(gerr, e, "encoded mode flag")
            `CHK(viol(got), e, "encoded mode char")
        end
        $display("encoded modes done");
        send(8'h01, 2'h0, 1'b0, 1'b0, txpe_pkg::LVL_M, 4'h5, 1'b1);
        `CHK(viol(got), 1'b1, "buffer error char")
        `CHK(gerr, 1'b1, "buffer error flag")
        wb(1'b0, 8'hFC, 32'h00000000, rd);
        `CHK(rd, 32'h00000000, "unmapped read")
        $display("buffer error and bus done");
        wrap_up();
    end
endmodule

// *** txpe_host_model.sv ***
// Host model: drives the parallel character and configuration pins.
// Assumes the bench calls put just after a rising clock edge.
`timescale 1ns/1ps
module txpe_host_model (
    // Character and configuration pins
    output logic [7:0] tx_data_out,
    output logic [1:0] tx_control_out,
    output logic special_char_select_out,
    output logic tx_odd_parity_bit_out,
    output logic [1:0] parity_check_control_out,
    output logic [3:0] tx_mode_select_out
);
    initial begin
        tx_data_out = 8'h00;
        tx_control_out = 2'h0;
        special_char_select_out = 1'b0;
        tx_odd_parity_bit_out = 1'b1;
        parity_check_control_out = 2'h0;
        tx_mode_select_out = 4'h0;
    end
    // All fields change together and hold until the next put
    task automatic put(input logic [7:0] d, input logic [1:0] c,
            input logic s, input logic p, input logic [1:0] pc,
            input logic [3:0] md);
        tx_data_out <= d;
        tx_control_out <= c;
        special_char_select_out <= s;
        tx_odd_parity_bit_out <= p;
        parity_check_control_out <= pc;
        // Factory test modes are never chosen, only LL and encoded ones
        tx_mode_select_out <= md;
    endtask
endmodule

// *** txpe_pkg.sv ***
// Constants shared by the transmit parity check and line encoder.
// Assumes a single 250 MHz clock; one character every ten clock cycles.
package txpe_pkg;

    // Three-level pin coding used by the mode and parity control inputs
    localparam logic [1:0] LVL_L = 2'h0;
    localparam logic [1:0] LVL_M = 2'h1;
    localparam logic [1:0] LVL_H = 2'h2;

    // Character timing: one serial bit per clock, ten bits per character
    localparam int CHAR_CYCLES = 10;
    localparam logic [3:0] CNT_LAST = 4'h9;
    localparam logic [3:0] CNT_LOAD = 4'h8;

    // Register map (byte addresses)
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_ERRCNT = 8'h08;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int CTRL_BIST_BIT = 0;
    localparam int CTRL_FILL_BIT = 1;

    // Fixed characters; VIOL_STR is written a..j, left bit sent first
    localparam logic [9:0] VIOL_STR = 10'h278;
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [4:0] K28_X = 5'h1C;
    localparam logic [5:0] K28_6B = 6'h0F;
    localparam logic [3:0] WS_REMAIN = 4'hF;
    localparam logic [8:0] LFSR_SEED = 9'h1FF;

    // 5b/6b codes, negative running disparity form, a..i with a as MSB
    localparam logic [5:0] TAB6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    // 3b/4b codes, negative running disparity form, f..j with f as MSB
    localparam logic [3:0] TAB4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] A7_4B = 4'h7;
    // Second special-code table: inputs 08..0B name the x.7 specials
    localparam logic [7:0] SPEC_TAB2 [4] = '{8'hF7, 8'hFB, 8'hFD, 8'hFE};

    typedef enum logic [1:0] {
        TXPE_CH_DATA = 2'b00,
        TXPE_CH_FILL = 2'b01,
        TXPE_CH_SPEC = 2'b10,
        TXPE_CH_WSYNC = 2'b11
    } txpe_char_e;

    typedef enum logic [1:0] {
        TXPE_WS_IDLE = 2'b00,
        TXPE_WS_ATOMIC = 2'b01,
        TXPE_WS_INTR = 2'b10
    } txpe_ws_e;

endpackage
